// ===== rtl/srlem_pkg.sv
/*
 * Shared constants and carrier types for the serial lane error monitor.
 * Assumes an 8-lane receiver and a 12-bit serial control port address.
 */
`default_nettype none

package srlem_pkg;

    // ***************************************************************
    // register addresses
    // ***************************************************************
    localparam logic [11:0] ADDR_DENSITY_CW  = 12'h45a;
    localparam logic [11:0] ADDR_SPARE_ONE   = 12'h45b;
    localparam logic [11:0] ADDR_SPARE_TWO   = 12'h45c;
    localparam logic [11:0] ADDR_CHECKSUM    = 12'h45d;
    localparam logic [11:0] ADDR_ERR_SELECT  = 12'h46b;
    localparam logic [11:0] ADDR_DESKEW      = 12'h46c;
    localparam logic [11:0] ADDR_DISP_CTRL   = 12'h46d;
    localparam logic [11:0] ADDR_MISS_CTRL   = 12'h46e;

    // ***************************************************************
    // reset values and field sizes
    // ***************************************************************
    localparam int          NUM_LANES        = 8;
    localparam logic        RST_HIGH_DENSITY = 1'h1;
    localparam logic [4:0]  RST_CTRL_WORDS   = 5'h00;
    localparam logic [7:0]  RST_SPARE        = 8'h00;
    localparam logic [7:0]  RST_CHECKSUM     = 8'h45;
    localparam logic [7:0]  RST_DESKEW       = 8'h0f;
    localparam logic [7:0]  COUNT_MAX        = 8'hff;
    localparam logic [7:0]  COUNT_ZERO       = 8'h00;
    localparam logic [7:0]  THRESHOLD_OFF    = 8'h00;
    localparam logic [7:0]  LANE_ONE_HOT     = 8'h01;

    // ***************************************************************
    // counter type selector codes
    // ***************************************************************
    localparam logic [1:0]  KIND_DISPARITY   = 2'h0;
    localparam logic [1:0]  KIND_TABLE_MISS  = 2'h1;
    localparam logic [1:0]  KIND_UNEXP_CTRL  = 2'h2;

    // ***************************************************************
    // carrier types
    // ***************************************************************
    typedef struct packed {
        logic       irq_clear;
        logic       counter_off;
        logic       counter_clear;
        logic [1:0] rsvd;
        logic [2:0] lane;
    } srlem_cmd_t;

    typedef struct packed {
        logic       rsvd_hi;
        logic [2:0] counter_lane_pick;
        logic [1:0] rsvd_lo;
        logic [1:0] counter_type_pick;
    } srlem_sel_t;

    typedef struct packed {
        logic [7:0] disparity;
        logic [7:0] table_miss;
        logic [7:0] unexp_ctrl;
    } srlem_err_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } srlem_req_t;

endpackage : srlem_pkg

`default_nettype wire

// ===== rtl/srlem_monitor.sv
/*
 * Lane error monitor: link parameter fields, deskew mask, per-lane error
 * counters with disparity and table miss threshold status, and lane-addressed command registers.
 * Assumes the serial control port decoder delivers one-cycle read and
 * write strobes synchronous to mclk_i, and that the link parameter
 * threshold lives elsewhere and arrives on threshold_i.
 */
// Operation
// - An 8-bit lane 0 checksum field exists and resets to 0x45.
// - Writing lane and type picks selects which count reads back there.
// - Type 00 picks disparity, 01 table miss, 10 unexpected control counts.
// - Each set bit of the deskew mask enables deskew; reset enables lanes 0-3.
// - A lane's disparity status bit sets when its count reaches threshold.
// - A lane's table miss status bit sets when its count reaches threshold.
// - Disparity control bit 7 clears the named lane's disparity interrupt.
// - Disparity control bit 6 disables the named lane's disparity counter.
// - Disparity control bit 5 zeroes the named lane's disparity counter.
// - Table miss control bits 7, 6, 5 clear irq, disable, zero for the lane.
// - The low three bits of each control write name the target lane.
// - Status is read at the addresses that take commands; counts at the select address.
`timescale 1ns/1ps
`default_nettype none

module srlem_monitor
(
    input  wire logic               mclk_i,
    input  wire logic               resetn_i,
    input  wire srlem_pkg::srlem_req_t req_i,
    input  wire srlem_pkg::srlem_err_t lane_err_i,
    input  wire logic [7:0]         threshold_i,
    output logic [7:0]              reg_rdata_o,
    output logic                    high_density_flag_o,
    output logic [4:0]              control_words_per_frame_o,
    output logic [7:0]              lane0_checksum_o,
    output logic [7:0]              deskew_mask_o,
    output logic [7:0]              disparity_threshold_hit_o,
    output logic [7:0]              table_miss_threshold_hit_o
);
    import srlem_pkg::*;

    // ***************************************************************
    // helpers
    // ***************************************************************
    function automatic logic [7:0] lane_mask(input logic go,
                                             input logic [2:0] lane);
        lane_mask = go ? (LANE_ONE_HOT << lane) : COUNT_ZERO;
    endfunction : lane_mask

    function automatic logic [7:0] next_count(input logic [7:0] cnt,
                                              input logic       err,
                                              input logic       off,
                                              input logic       clr);
        if (clr)
            next_count = COUNT_ZERO;
        else if (err && !off && cnt != COUNT_MAX)
            next_count = 8'(cnt + 8'h01);
        else
            next_count = cnt;
    endfunction : next_count

    function automatic logic reached(input logic [7:0] cnt,
                                     input logic [7:0] thr);
        reached = (thr != THRESHOLD_OFF) && (cnt >= thr);
    endfunction : reached

    // ***************************************************************
    // command decode
    // ***************************************************************
    logic        wr_disp;
    logic        wr_miss;
    srlem_cmd_t  cmd;
    logic [7:0]  disp_irq_clr;
    logic [7:0]  disp_off_set;
    logic [7:0]  disp_cnt_clr;
    logic [7:0]  miss_irq_clr;
    logic [7:0]  miss_off_set;
    logic [7:0]  miss_cnt_clr;

    assign cmd     = srlem_cmd_t'(req_i.wdata);
    assign wr_disp = req_i.wr && (req_i.addr == ADDR_DISP_CTRL);
    assign wr_miss = req_i.wr && (req_i.addr == ADDR_MISS_CTRL);

    assign disp_irq_clr = lane_mask(wr_disp && cmd.irq_clear, cmd.lane);
    assign disp_off_set = lane_mask(wr_disp && cmd.counter_off, cmd.lane);
    assign disp_cnt_clr = lane_mask(wr_disp && cmd.counter_clear, cmd.lane);
    assign miss_irq_clr = lane_mask(wr_miss && cmd.irq_clear, cmd.lane);
    assign miss_off_set = lane_mask(wr_miss && cmd.counter_off, cmd.lane);
    assign miss_cnt_clr = lane_mask(wr_miss && cmd.counter_clear, cmd.lane);

    // ***************************************************************
    // link parameter and deskew registers
    // ***************************************************************
    logic [7:0]  spare_one;
    logic [7:0]  spare_two;
    srlem_sel_t  sel;

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            high_density_flag_o       <= RST_HIGH_DENSITY;
            control_words_per_frame_o <= RST_CTRL_WORDS;
            spare_one                 <= RST_SPARE;
            spare_two                 <= RST_SPARE;
            lane0_checksum_o          <= RST_CHECKSUM;
            deskew_mask_o             <= RST_DESKEW;
            sel                       <= srlem_sel_t'(COUNT_ZERO);
        end
        else if (req_i.wr)
        begin
            case (req_i.addr)
                ADDR_DENSITY_CW:
                begin
                    // software keeps these legal for the frame size
                    high_density_flag_o       <= req_i.wdata[7];
                    control_words_per_frame_o <= req_i.wdata[4:0];
                end
                ADDR_SPARE_ONE:  spare_one        <= req_i.wdata;
                ADDR_SPARE_TWO:  spare_two        <= req_i.wdata;
                ADDR_CHECKSUM:   lane0_checksum_o <= req_i.wdata;
                ADDR_DESKEW:     deskew_mask_o    <= req_i.wdata;
                ADDR_ERR_SELECT: sel              <= srlem_sel_t'(req_i.wdata);
                default: ;
            endcase
        end
    end

    // ***************************************************************
    // per-lane error counters and disables
    // ***************************************************************
    logic [7:0] disp_cnt [NUM_LANES];
    logic [7:0] miss_cnt [NUM_LANES];
    logic [7:0] ucc_cnt  [NUM_LANES];
    logic [7:0] disp_off;
    logic [7:0] miss_off;

    // a counter reset also re-enables the counter
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            disp_off <= COUNT_ZERO;
            miss_off <= COUNT_ZERO;
        end
        else
        begin
            disp_off <= (disp_off | disp_off_set) & ~disp_cnt_clr;
            miss_off <= (miss_off | miss_off_set) & ~miss_cnt_clr;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            for (int l = 0; l < NUM_LANES; l++)
            begin
                disp_cnt[l] <= COUNT_ZERO;
                miss_cnt[l] <= COUNT_ZERO;
                ucc_cnt[l]  <= COUNT_ZERO;
            end
        end
        else
        begin
            for (int l = 0; l < NUM_LANES; l++)
            begin
                disp_cnt[l] <= next_count(disp_cnt[l],
                    lane_err_i.disparity[l], disp_off[l],
                    disp_cnt_clr[l]);
                miss_cnt[l] <= next_count(miss_cnt[l],
                    lane_err_i.table_miss[l], miss_off[l],
                    miss_cnt_clr[l]);
                ucc_cnt[l]  <= next_count(ucc_cnt[l],
                    lane_err_i.unexp_ctrl[l], 1'b0, 1'b0);
            end
        end
    end

    // ***************************************************************
    // threshold status, set wins over clear
    // ***************************************************************
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            disparity_threshold_hit_o  <= COUNT_ZERO;
            table_miss_threshold_hit_o <= COUNT_ZERO;
        end
        else
        begin
            for (int l = 0; l < NUM_LANES; l++)
            begin
                disparity_threshold_hit_o[l] <=
                    reached(disp_cnt[l], threshold_i) ||
                    (disparity_threshold_hit_o[l] && !disp_irq_clr[l]);
                table_miss_threshold_hit_o[l] <=
                    reached(miss_cnt[l], threshold_i) ||
                    (table_miss_threshold_hit_o[l] && !miss_irq_clr[l]);
            end
        end
    end

    // ***************************************************************
    // read data
    // ***************************************************************
    logic [7:0] sel_count;

    always_comb
    begin
        case (sel.counter_type_pick)
            KIND_DISPARITY:  sel_count = disp_cnt[sel.counter_lane_pick];
            KIND_TABLE_MISS: sel_count = miss_cnt[sel.counter_lane_pick];
            KIND_UNEXP_CTRL: sel_count = ucc_cnt[sel.counter_lane_pick];
            default:         sel_count = COUNT_ZERO;
        endcase
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            reg_rdata_o <= COUNT_ZERO;
        else if (req_i.rd)
        begin
            case (req_i.addr)
                ADDR_DENSITY_CW:
                    reg_rdata_o <= {high_density_flag_o, 2'h0,
                                    control_words_per_frame_o};
                ADDR_SPARE_ONE:  reg_rdata_o <= spare_one;
                ADDR_SPARE_TWO:  reg_rdata_o <= spare_two;
                ADDR_CHECKSUM:   reg_rdata_o <= lane0_checksum_o;
                ADDR_ERR_SELECT: reg_rdata_o <= sel_count;
                ADDR_DESKEW:     reg_rdata_o <= deskew_mask_o;
                ADDR_DISP_CTRL:  reg_rdata_o <= disparity_threshold_hit_o;
                ADDR_MISS_CTRL:  reg_rdata_o <= table_miss_threshold_hit_o;
                default:         reg_rdata_o <= COUNT_ZERO;
            endcase
        end
    end

    // ***************************************************************
    // assertions
    // ***************************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    count_read_a:
    assert property (req_i.rd && req_i.addr == ADDR_ERR_SELECT
                     |=> reg_rdata_o == $past(sel_count))
        else $error("count readback mismatch");

    status_read_a:
    assert property (req_i.rd && req_i.addr == ADDR_DISP_CTRL
                     |=> reg_rdata_o == $past(disparity_threshold_hit_o))
        else $error("disparity status readback mismatch");

    deskew_write_a:
    assert property (req_i.wr && req_i.addr == ADDR_DESKEW
                     |=> deskew_mask_o == $past(req_i.wdata))
        else $error("deskew mask not written");

    miss_read_a:
    assert property (req_i.rd && req_i.addr == ADDR_MISS_CTRL
                     |=> reg_rdata_o == $past(table_miss_threshold_hit_o))
        else $error("table miss status readback mismatch");

    irq_clear_a:
    assert property (wr_disp && cmd.irq_clear
                     && !reached(disp_cnt[cmd.lane], threshold_i)
                     |=> !disparity_threshold_hit_o[$past(cmd.lane)])
        else $error("disparity interrupt not cleared");

    miss_irq_a:
    assert property (wr_miss && cmd.irq_clear
                     && !reached(miss_cnt[cmd.lane], threshold_i)
                     |=> !table_miss_threshold_hit_o[$past(cmd.lane)])
        else $error("table miss interrupt not cleared");

    counter_clear_a:
    assert property (wr_disp && cmd.counter_clear
                     |=> disp_cnt[$past(cmd.lane)] == COUNT_ZERO)
        else $error("disparity counter not reset");

    counter_off_a:
    assert property (wr_disp && cmd.counter_off && !cmd.counter_clear
                     |=> disp_off[$past(cmd.lane)])
        else $error("disparity counter not disabled");

    miss_clear_a:
    assert property (wr_miss && cmd.counter_clear
                     |=> miss_cnt[$past(cmd.lane)] == COUNT_ZERO
                         && !miss_off[$past(cmd.lane)])
        else $error("table miss counter not reset");

    miss_off_a:
    assert property (wr_miss && cmd.counter_off && !cmd.counter_clear
                     |=> miss_off[$past(cmd.lane)])
        else $error("table miss counter not disabled");

    // ***************************************************************
    // per-lane assertions
    // ***************************************************************
    for (genvar g = 0; g < NUM_LANES; g++)
    begin : lane_chk
        disp_hit_a:
        assert property (@(posedge mclk_i) disable iff (!resetn_i)
                         threshold_i != THRESHOLD_OFF
                         && disp_cnt[g] >= threshold_i
                         |=> disparity_threshold_hit_o[g])
            else $error("disparity status not set at threshold");

        miss_hit_a:
        assert property (@(posedge mclk_i) disable iff (!resetn_i)
                         threshold_i != THRESHOLD_OFF
                         && miss_cnt[g] >= threshold_i
                         |=> table_miss_threshold_hit_o[g])
            else $error("table miss status not set at threshold");

        counter_hold_a:
        assert property (@(posedge mclk_i) disable iff (!resetn_i)
                         disp_off[g] && !disp_cnt_clr[g]
                         |=> disp_cnt[g] == $past(disp_cnt[g]))
            else $error("disabled counter moved");

        miss_hold_a:
        assert property (@(posedge mclk_i) disable iff (!resetn_i)
                         miss_off[g] && !miss_cnt_clr[g]
                         |=> miss_cnt[g] == $past(miss_cnt[g]))
            else $error("disabled table miss counter moved");

        count_step_a:
        assert property (@(posedge mclk_i) disable iff (!resetn_i)
                         lane_err_i.disparity[g] && !disp_off[g]
                         && !disp_cnt_clr[g] && disp_cnt[g] != COUNT_MAX
                         |=> disp_cnt[g] == 8'($past(disp_cnt[g]) + 8'h01))
            else $error("enabled counter did not step");

        miss_step_a:
        assert property (@(posedge mclk_i) disable iff (!resetn_i)
                         lane_err_i.table_miss[g] && !miss_off[g]
                         && !miss_cnt_clr[g] && miss_cnt[g] != COUNT_MAX
                         |=> miss_cnt[g] == 8'($past(miss_cnt[g]) + 8'h01))
            else $error("table miss counter did not step");
    end

endmodule : srlem_monitor

`default_nettype wire

// ===== test/srlem_lane_tx.sv
/*
 * Behavioural transmitter side: raises per-lane error pulses.
 * Assumes the bench calls send() just after a rising edge of mclk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module srlem_lane_tx
(
    input  wire logic               mclk_i,
    output var srlem_pkg::srlem_err_t err_o
);
    import srlem_pkg::*;

    initial err_o = '0;

    // ***************************************************************
    // error injection, one pulse per error, then gap idle cycles after each
    // ***************************************************************
    task automatic send(input logic [1:0] kind, input logic [2:0] lane,
                        input int n, input int gap);
        for (int i = 0; i < n; i++)
        begin
            case (kind)
                KIND_DISPARITY:  err_o.disparity[lane] = 1'b1;
                KIND_TABLE_MISS: err_o.table_miss[lane] = 1'b1;
                default:         err_o.unexp_ctrl[lane] = 1'b1;
            endcase
            @(posedge mclk_i);
            #1;
            err_o = '0;
            repeat (gap)
            begin
                @(posedge mclk_i);
                #1;
            end
        end
    endtask : send
endmodule : srlem_lane_tx

`default_nettype wire

// ===== test/tb_top.sv
/*
 * Self-checking bench for the lane error monitor.
 * Assumes the strobe port contract: writes land at the strobe edge,
 * read data is registered at the read strobe edge and valid just after it.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import srlem_pkg::*;

    logic        mclk_i;
    logic        resetn_i;
    srlem_req_t  req;
    srlem_err_t  lane_err;
    logic [7:0]  thr;
    logic [7:0]  rdata;
    logic        hd;
    logic [4:0]  cf;
    logic [7:0]  csum;
    logic [7:0]  dsk;
    logic [7:0]  disp_hit;
    logic [7:0]  miss_hit;
    int          errors;
    int          check_count;

    srlem_monitor dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .req_i(req),
        .lane_err_i(lane_err), .threshold_i(thr), .reg_rdata_o(rdata),
        .high_density_flag_o(hd), .control_words_per_frame_o(cf),
        .lane0_checksum_o(csum), .deskew_mask_o(dsk),
        .disparity_threshold_hit_o(disp_hit),
        .table_miss_threshold_hit_o(miss_hit));
    srlem_lane_tx tx (.mclk_i(mclk_i), .err_o(lane_err));

    initial
    begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    // ***************************************************************
    // access tasks
    // ***************************************************************
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(posedge mclk_i);
        #1;
        req.wr = 1'b0;
        @(posedge mclk_i);
        #1;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] e,
                      input string nm);
        req.rd = 1'b1;
        req.addr = a;
        @(posedge mclk_i);
        #1;
        req.rd = 1'b0;
        chk(nm, e, rdata);
        @(posedge mclk_i);
        #1;
    endtask : rd

    task automatic cnt(input logic [2:0] l, input logic [1:0] k,
                       input logic [7:0] e);
        wr(ADDR_ERR_SELECT, {1'b0, l, 2'b00, k});
        rd(ADDR_ERR_SELECT, e, "count");
    endtask : cnt

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    initial
    begin
        #400000;
        errors++;
        test_done();
    end

    // ***************************************************************
    // tests
    // ***************************************************************
    initial
    begin
        errors = 0;
        check_count = 0;
        resetn_i = 1'b0;
        req = '0;
        thr = 8'h03;
        repeat (2) @(posedge mclk_i);
        #1;
        resetn_i = 1'b1;
        rd(ADDR_DENSITY_CW, 8'h80, "hd_cf");
        rd(ADDR_SPARE_ONE, 8'h00, "spare1");
        rd(ADDR_SPARE_TWO, 8'h00, "spare2");
        rd(ADDR_CHECKSUM, 8'h45, "checksum");
        rd(ADDR_DESKEW, 8'h0f, "deskew");
        rd(ADDR_DISP_CTRL, 8'h00, "disp_stat");
        rd(ADDR_MISS_CTRL, 8'h00, "miss_stat");
        rd(12'h470, 8'h00, "unmapped");
        chk("deskew_o", 8'h0f, dsk);
        $display("reset test done");

        wr(ADDR_DENSITY_CW, 8'h00);
        chk("hd_o", 8'h00, {7'h00, hd});
        wr(ADDR_DENSITY_CW, 8'he0);
        rd(ADDR_DENSITY_CW, 8'h80, "hd_cf");
        chk("cf_o", 8'h00, {3'h0, cf});
        wr(ADDR_CHECKSUM, 8'h5a);
        rd(ADDR_CHECKSUM, 8'h5a, "checksum");
        chk("csum_o", 8'h5a, csum);
        wr(ADDR_DESKEW, 8'ha5);
        rd(ADDR_DESKEW, 8'ha5, "deskew");
        chk("deskew_o", 8'ha5, dsk);
        wr(ADDR_SPARE_ONE, 8'h3c);
        rd(ADDR_SPARE_ONE, 8'h3c, "spare1");
        wr(ADDR_SPARE_TWO, 8'hc3);
        rd(ADDR_SPARE_TWO, 8'hc3, "spare2");
        $display("config test done");

        tx.send(KIND_DISPARITY, 3'd2, 2, 1);
        tx.send(KIND_TABLE_MISS, 3'd5, 3, 3);
        tx.send(KIND_UNEXP_CTRL, 3'd7, 4, 1);
        cnt(3'd2, KIND_DISPARITY, 8'h02);
        cnt(3'd5, KIND_TABLE_MISS, 8'h03);
        cnt(3'd7, KIND_UNEXP_CTRL, 8'h04);
        cnt(3'd7, 2'h3, 8'h00);
        cnt(3'd5, KIND_DISPARITY, 8'h00);
        rd(ADDR_DISP_CTRL, 8'h00, "disp_stat");
        rd(ADDR_MISS_CTRL, 8'h20, "miss_stat");
        tx.send(KIND_DISPARITY, 3'd2, 1, 2);
        rd(ADDR_DISP_CTRL, 8'h04, "disp_stat");
        chk("disp_o", 8'h04, disp_hit);
        $display("count test done");

        wr(ADDR_DISP_CTRL, 8'h42);
        tx.send(KIND_DISPARITY, 3'd2, 2, 1);
        cnt(3'd2, KIND_DISPARITY, 8'h03);
        wr(ADDR_DISP_CTRL, 8'h22);
        cnt(3'd2, KIND_DISPARITY, 8'h00);
        cnt(3'd5, KIND_TABLE_MISS, 8'h03);
        wr(ADDR_DISP_CTRL, 8'h82);
        rd(ADDR_DISP_CTRL, 8'h00, "disp_stat");
        tx.send(KIND_DISPARITY, 3'd2, 1, 1);
        cnt(3'd2, KIND_DISPARITY, 8'h01);
        wr(ADDR_MISS_CTRL, 8'ha5);
        wr(ADDR_MISS_CTRL, 8'h85);
        rd(ADDR_MISS_CTRL, 8'h00, "miss_stat");
        chk("miss_o", 8'h00, miss_hit);
        wr(ADDR_MISS_CTRL, 8'h45);
        tx.send(KIND_TABLE_MISS, 3'd5, 1, 1);
        cnt(3'd5, KIND_TABLE_MISS, 8'h00);
        wr(ADDR_MISS_CTRL, 8'h25);
        tx.send(KIND_TABLE_MISS, 3'd5, 1, 1);
        thr = 8'h01;
        cnt(3'd5, KIND_TABLE_MISS, 8'h01);
        rd(ADDR_MISS_CTRL, 8'h20, "miss_stat");
        rd(ADDR_DISP_CTRL, 8'h04, "disp_stat");
        thr = 8'h00;
        wr(ADDR_MISS_CTRL, 8'h85);
        rd(ADDR_MISS_CTRL, 8'h00, "miss_stat");
        chk("disp_o", 8'h04, disp_hit);
        $display("command test done");
        test_done();
    end
endmodule : tb_top

`default_nettype wire
